// File: ldi_device.sv
// LED driver target: serial register access and bank dimming outputs.
// Link logic runs on the master's serial clock; PWM runs on clk.
//
// Operation
// - First byte: seven-bit address, MSB first, direction
// - Direction bit one reads, zero writes
// - Write: pointer byte then eight-bit data bytes
// - Sequential write fills consecutive registers upward
// - Fifth data byte wraps to starting register
// - Pointer, repeated start, write, one data byte
// - Pointerless read returns last write-addressed register
// - Sequential read continues while master acknowledges
// - Random read: pointer, repeated start, read, nack
// - Current code sets bank current linearly
// - Enable bits 5:0 gate the six LEDs
// - Software disables both LEDs of a bank
// - Log global dimming; FFh switches outputs off
// - Linear: duty minus global dimming code
// - Linear: global not below duty gives zero
// - Log duty: 00h off, FFh full
// - Eight-bit log code mapped to twelve-bit duty
// - Linear duty steps of one 256th
`timescale 1ns/1ns
module ldi_device
   import ldi_pkg::*;
(
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst,
   // Serial link
   ldi_link_if.dev    link,
   // Dimming mode, high selects linear
   input  wire logic  linear_mode,
   // LED gates
   output logic       first_bank_led_one,
   output logic       first_bank_led_two,
   output logic       second_bank_led_one,
   output logic       second_bank_led_two,
   output logic       third_bank_led_one,
   output logic       third_bank_led_two,
   // Bank current codes to the sinks
   output logic [7:0] bank_a_current,
   output logic [7:0] bank_b_current,
   output logic [7:0] bank_c_current
);
   import ldi_pkg::*;

   // Link domain
   logic           start_tog;
   logic           stop_tog;
   logic           start_seen;
   logic           stop_seen;
   logic [3:0]     bit_cnt;
   logic [6:0]     shift;
   ldi_dev_state_t state;
   logic           ack_now;
   logic           ptr_given;
   logic [7:0]     ptr;
   logic [7:0]     base;
   logic [7:0]     last;
   logic [1:0]     widx;
   logic [7:0]     tx;
   logic           upd_tog;
   logic [7:0]     regs [NUM_REGS];

   // System domain
   logic           upd_s;
   logic           upd_d;
   logic [7:0]     sh [NUM_REGS];
   logic [4:0]     pre_cnt;
   logic [11:0]    pwm_cnt;
   logic [11:0]    duty [3];
   logic [5:0]     led_q;

   wire            new_frame = start_tog != start_seen;
   wire            byte_end  = !new_frame && bit_cnt == LAST_DATA_BIT;
   wire            ack_slot  = !new_frame && bit_cnt == ACK_BIT;
   wire [7:0]      rx        = {shift, link.sda};
   wire            addr_hit  = rx[7:1] == TARGET_ADDR;

   function automatic logic [7:0] reg_rd(input logic [7:0] a);
      reg_rd = (a < 8'(NUM_REGS)) ? regs[a[2:0]] : RESET_VALUE;
   endfunction

   // Start and stop are seen on data edges while the clock is high;
   // the next clock edge follows by protocol, so toggles are stable.
   always_ff @(negedge link.sda or posedge rst) begin
      if (rst) begin
         start_tog <= 1'b0;
      end else if (link.scl) begin
         start_tog <= ~start_tog;
      end
   end

   always_ff @(posedge link.sda or posedge rst) begin
      if (rst) begin
         stop_tog <= 1'b0;
      end else if (link.scl) begin
         stop_tog <= ~stop_tog;
      end
   end

   // Bit framing, nine clocks per byte
   always_ff @(posedge link.scl or posedge rst) begin
      if (rst) begin
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
         bit_cnt    <= 4'h0;
         shift      <= 7'h00;
      end else if (new_frame) begin
         start_seen <= start_tog;
         stop_seen  <= stop_tog;
         bit_cnt    <= 4'h1;
         shift      <= {6'h00, link.sda};
      end else if (ack_slot) begin
         bit_cnt    <= 4'h0;
      end else begin
         bit_cnt    <= bit_cnt + 4'h1;
         shift      <= {shift[5:0], link.sda};
      end
   end

   // Transfer state
   always_ff @(posedge link.scl or posedge rst) begin
      if (rst) begin
         state     <= DST_IDLE;
         ack_now   <= 1'b0;
         ptr_given <= 1'b0;
      end else if (new_frame) begin
         state   <= DST_ADDR;
         ack_now <= 1'b0;
         // Only a stop forgets the pointer; a repeated start keeps it
         if (stop_tog != stop_seen) begin
            ptr_given <= 1'b0;
         end
      end else if (byte_end) begin
         case (state)
            DST_ADDR: begin
               if (addr_hit) begin
                  ack_now <= 1'b1;
                  if (rx[0]) begin
                     state <= DST_RDATA;
                  end else if (ptr_given) begin
                     state <= DST_WDATA;
                  end else begin
                     state <= DST_PTR;
                  end
               end else begin
                  state <= DST_IDLE;
               end
            end
            DST_PTR: begin
               ack_now   <= 1'b1;
               ptr_given <= 1'b1;
               state     <= DST_WDATA;
            end
            DST_WDATA: begin
               ack_now <= 1'b1;
            end
            DST_RDATA: begin
               ack_now <= 1'b0;
            end
            default: begin
               state <= DST_IDLE;
            end
         endcase
      end else if (ack_slot) begin
         ack_now <= 1'b0;
         // Master leaves data high after its final byte
         if (state == DST_RDATA && !ack_now && link.sda) begin
            state <= DST_IDLE;
         end
      end
   end

   // Pointers
   always_ff @(posedge link.scl or posedge rst) begin
      if (rst) begin
         ptr  <= RESET_VALUE;
         base <= RESET_VALUE;
         last <= RESET_VALUE;
         widx <= 2'h0;
      end else if (byte_end && state == DST_PTR) begin
         ptr  <= rx;
         base <= rx;
         last <= rx;
         widx <= 2'h0;
      end else if (byte_end && state == DST_WDATA) begin
         last <= ptr;
         if (widx == WRAP_LAST) begin
            ptr  <= base;
            widx <= 2'h0;
         end else begin
            ptr  <= ptr + 8'h01;
            widx <= widx + 2'h1;
         end
      end else if (ack_slot && state == DST_RDATA) begin
         if (ack_now) begin
            ptr <= last + 8'h01;
         end else if (!link.sda) begin
            ptr <= ptr + 8'h01;
         end
      end
   end

   // Register file and read shifter
   always_ff @(posedge link.scl or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs[i] <= RESET_VALUE;
         end
         tx      <= RESET_VALUE;
         upd_tog <= 1'b0;
      end else if (byte_end && state == DST_WDATA) begin
         // Writes outside this group are acknowledged and dropped
         if (ptr == REG_CHAN_EN) begin
            regs[ptr[2:0]] <= {2'b00, rx[CHAN_EN_W-1:0]};
         end else if (ptr < 8'(NUM_REGS)) begin
            regs[ptr[2:0]] <= rx;
         end
         upd_tog <= ~upd_tog;
      end else if (ack_slot && state == DST_RDATA) begin
         if (ack_now) begin
            tx <= reg_rd(last);
         end else begin
            tx <= reg_rd(ptr);
         end
      end else if (state == DST_RDATA && bit_cnt < ACK_BIT) begin
         tx <= {tx[6:0], 1'b0};
      end
   end

   // Data line changes only while the clock is low
   always_ff @(negedge link.scl or posedge rst) begin
      if (rst) begin
         link.dev_sda_oe_n <= 1'b1;
      end else if (ack_now && bit_cnt == ACK_BIT) begin
         link.dev_sda_oe_n <= 1'b0;
      end else if (state == DST_RDATA && bit_cnt < ACK_BIT && !ack_now) begin
         link.dev_sda_oe_n <= tx[7];
      end else begin
         link.dev_sda_oe_n <= 1'b1;
      end
   end

   // Register copy into the system domain; toggle handshake,
   // the link cannot write again within a byte time.
   ldi_sync u_upd_sync (
      .clk (clk),
      .rst (rst),
      .d   (upd_tog),
      .q   (upd_s)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         upd_d <= 1'b0;
         for (int i = 0; i < NUM_REGS; i++) begin
            sh[i] <= RESET_VALUE;
         end
      end else begin
         upd_d <= upd_s;
         if (upd_s != upd_d) begin
            for (int i = 0; i < NUM_REGS; i++) begin
               sh[i] <= regs[i];
            end
         end
      end
   end

   // Roughly 0.17 dB per step: halves every 35 codes, linear between
   function automatic logic [11:0] log_duty(input logic [7:0] code, input logic [7:0] g);
      logic [8:0]  n;
      logic [8:0]  r;
      logic [2:0]  s;
      logic [11:0] m;
      n = {1'b0, ~code} + {1'b0, g};
      r = n % LOG_OCTAVE;
      s = 3'(n / LOG_OCTAVE);
      m = DUTY_FULL - 12'(r) * LOG_SLOPE;
      if (code == CODE_ZERO || g == DIM_OFF || n >= LOG_FLOOR) begin
         log_duty = 12'h000;
      end else begin
         log_duty = m >> s;
      end
   endfunction

   function automatic logic [11:0] lin_duty(input logic [7:0] code, input logic [7:0] g);
      logic [7:0] eff;
      eff = (code > g) ? code - g : CODE_ZERO;
      lin_duty = {eff, eff[7:4]};
   endfunction

   always_comb begin
      for (int b = 0; b < 3; b++) begin
         duty[b] = linear_mode ? lin_duty(sh[5 + b], sh[4]) : log_duty(sh[5 + b], sh[4]);
      end
   end

   // PWM timebase near 285 Hz
   always_ff @(posedge clk) begin
      if (rst) begin
         pre_cnt <= 5'h00;
         pwm_cnt <= 12'h000;
      end else if (pre_cnt == 5'(PWM_PRESCALE - 1)) begin
         pre_cnt <= 5'h00;
         pwm_cnt <= pwm_cnt + 12'h001;
      end else begin
         pre_cnt <= pre_cnt + 5'h01;
      end
   end

   // Outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         led_q          <= 6'h00;
         bank_a_current <= RESET_VALUE;
         bank_b_current <= RESET_VALUE;
         bank_c_current <= RESET_VALUE;
      end else begin
         for (int i = 0; i < 6; i++) begin
            led_q[i] <= sh[3][i] & ((duty[i / 2] == DUTY_FULL) | (pwm_cnt < duty[i / 2]));
         end
         bank_a_current <= sh[0];
         bank_b_current <= sh[1];
         bank_c_current <= sh[2];
      end
   end

   assign first_bank_led_one  = led_q[0];
   assign first_bank_led_two  = led_q[1];
   assign second_bank_led_one = led_q[2];
   assign second_bank_led_two = led_q[3];
   assign third_bank_led_one  = led_q[4];
   assign third_bank_led_two  = led_q[5];

endmodule

// File: ldi_pkg.sv
// Shared constants and types for the LED driver serial register link.
// Assumes a 20 MHz system clock on both ends.
package ldi_pkg;

   // Timing
   localparam int CLK_HZ          = 20_000_000;
   localparam int CLK_NS          = 50;
   localparam int SCL_QUARTER_NS  = 625;
   localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_NS - 1) / CLK_NS;
   localparam int PWM_HZ          = 285;
   localparam int PWM_PRESCALE    = CLK_HZ / (4096 * PWM_HZ);

   // Target address, value arbitrary
   localparam logic [6:0] TARGET_ADDR = 7'h3a;

   // Register offsets
   localparam logic [7:0] REG_A_CURRENT = 8'h00;
   localparam logic [7:0] REG_B_CURRENT = 8'h01;
   localparam logic [7:0] REG_C_CURRENT = 8'h02;
   localparam logic [7:0] REG_CHAN_EN   = 8'h03;
   localparam logic [7:0] REG_GLOBAL    = 8'h04;
   localparam logic [7:0] REG_A_DUTY    = 8'h05;
   localparam logic [7:0] REG_B_DUTY    = 8'h06;
   localparam logic [7:0] REG_C_DUTY    = 8'h07;
   localparam int         NUM_REGS      = 8;
   localparam int         CHAN_EN_W     = 6;
   localparam logic [7:0] RESET_VALUE   = 8'h00;

   // Byte framing
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT       = 4'h8;
   localparam logic [1:0] WRAP_LAST     = 2'h3;

   // Dimming codes
   localparam logic [7:0]  DIM_OFF    = 8'hff;
   localparam logic [7:0]  CODE_ZERO  = 8'h00;
   localparam logic [8:0]  LOG_OCTAVE = 9'h023;
   localparam logic [11:0] LOG_SLOPE  = 12'h03a;
   localparam logic [8:0]  LOG_FLOOR  = 9'h118;
   localparam logic [11:0] DUTY_FULL  = 12'hfff;

   // Host operations
   localparam logic [1:0] OP_START = 2'h0;
   localparam logic [1:0] OP_STOP  = 2'h1;
   localparam logic [1:0] OP_WRITE = 2'h2;
   localparam logic [1:0] OP_READ  = 2'h3;

   typedef enum logic [4:0] {
      DST_ADDR  = 5'b00001,
      DST_PTR   = 5'b00010,
      DST_WDATA = 5'b00100,
      DST_RDATA = 5'b01000,
      DST_IDLE  = 5'b10000
   } ldi_dev_state_t;

   typedef enum logic [1:0] {
      HST_IDLE = 2'b01,
      HST_RUN  = 2'b10
   } ldi_host_state_t;

endpackage

// File: ldi_link_if.sv
// Two-wire link between bus master and LED driver target.
// Both ends only pull the data line low; the level is resolved here.
`timescale 1ns/1ns
interface ldi_link_if;
   logic scl;
   logic host_sda_oe_n;
   logic dev_sda_oe_n;
   logic sda;

   // Open drain with pull-up
   assign sda = host_sda_oe_n & dev_sda_oe_n;

   modport host (output scl, output host_sda_oe_n, input sda);
   modport dev  (input scl, output dev_sda_oe_n, input sda);
endinterface

// File: ldi_sync.sv
// Two-flop level synchroniser.
// Assumes d is a level from another clock domain.
`timescale 1ns/1ns
module ldi_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Level
   input  wire logic d,
   output logic      q
);
   logic meta;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= 1'b0;
         q    <= 1'b0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// File: ldi_host.sv
// Bus master end: runs one start, stop, byte write or byte read per command.
// Makes the serial clock from clk by a quarter-period divider.
`timescale 1ns/1ns
module ldi_host
   import ldi_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Serial link
   ldi_link_if.host        link,
   // Command
   input  wire logic       cmd_valid,
   input  wire logic [1:0] cmd_op,
   input  wire logic [7:0] cmd_byte,
   input  wire logic       cmd_nack,
   output logic            cmd_ready,
   // Result
   output logic            done,
   output logic [7:0]      rd_byte,
   output logic            ack_ok
);
   import ldi_pkg::*;

   ldi_host_state_t state;
   logic [1:0]      op;
   logic [4:0]      q_cnt;
   logic [1:0]      phase;
   logic [3:0]      bit_idx;
   logic [7:0]      shift;
   logic            nack;
   logic            sda_s;

   wire tick    = state == HST_RUN && q_cnt == 5'(SCL_QUARTER_CYC - 1);
   wire is_byte = op == OP_WRITE || op == OP_READ;
   wire finish  = tick && phase == 2'h3 && (!is_byte || bit_idx == ACK_BIT);
   wire accept  = cmd_valid && cmd_ready;

   ldi_sync u_sda_sync (
      .clk (clk),
      .rst (rst),
      .d   (link.sda),
      .q   (sda_s)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         state     <= HST_IDLE;
         cmd_ready <= 1'b1;
         done      <= 1'b0;
         op        <= OP_STOP;
         nack      <= 1'b0;
      end else begin
         done <= finish;
         case (state)
            HST_IDLE: begin
               if (accept) begin
                  op        <= cmd_op;
                  nack      <= cmd_nack;
                  state     <= HST_RUN;
                  cmd_ready <= 1'b0;
               end
            end
            HST_RUN: begin
               if (finish) begin
                  state     <= HST_IDLE;
                  cmd_ready <= 1'b1;
               end
            end
            default: begin
               state <= HST_IDLE;
            end
         endcase
      end
   end

   // Quarter-period sequencing
   always_ff @(posedge clk) begin
      if (rst || accept) begin
         q_cnt   <= 5'h00;
         phase   <= 2'h0;
         bit_idx <= 4'h0;
      end else if (tick) begin
         q_cnt <= 5'h00;
         phase <= phase + 2'h1;
         if (phase == 2'h3) begin
            bit_idx <= bit_idx + 4'h1;
         end
      end else if (state == HST_RUN) begin
         q_cnt <= q_cnt + 5'h01;
      end
   end

   // Pins; data bits change while the clock is low, start and stop edges while it is high
   always_ff @(posedge clk) begin
      if (rst) begin
         link.scl           <= 1'b1;
         link.host_sda_oe_n <= 1'b1;
      end else if (tick) begin
         case (phase)
            2'h0: begin
               if (op == OP_START) begin
                  link.host_sda_oe_n <= 1'b1;
               end else if (op == OP_STOP) begin
                  link.host_sda_oe_n <= 1'b0;
               end else if (bit_idx == ACK_BIT) begin
                  link.host_sda_oe_n <= (op == OP_READ) ? nack : 1'b1;
               end else begin
                  link.host_sda_oe_n <= (op == OP_READ) | shift[7];
               end
            end
            2'h1: begin
               link.scl <= 1'b1;
            end
            2'h2: begin
               if (op == OP_START) begin
                  link.host_sda_oe_n <= 1'b0;
               end else if (op == OP_STOP) begin
                  link.host_sda_oe_n <= 1'b1;
               end
            end
            default: begin
               if (op != OP_STOP) begin
                  link.scl <= 1'b0;
               end
            end
         endcase
      end
   end

   // Shifting and sampling
   always_ff @(posedge clk) begin
      if (rst) begin
         shift   <= 8'h00;
         rd_byte <= 8'h00;
         ack_ok  <= 1'b0;
      end else if (accept) begin
         shift <= cmd_byte;
      end else if (tick && phase == 2'h2 && is_byte) begin
         if (bit_idx == ACK_BIT) begin
            ack_ok  <= ~sda_s;
            rd_byte <= shift;
         end else begin
            shift <= {shift[6:0], sda_s};
         end
      end
   end

endmodule

// File: ldi_link_monitor.sv
// Concurrent checks on the two-wire link between host and target.
// Assumes scl is slow against clk, so every wire edge is seen by clk sampling.
`timescale 1ns/1ns
module ldi_link_monitor
   import ldi_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Link
   input  wire logic scl,
   input  wire logic host_sda_oe_n,
   input  wire logic dev_sda_oe_n,
   input  wire logic sda
);
   logic       scl_q;
   logic       sda_q;
   logic       bit_open;
   logic       sda_r;
   logic       hoe_r;
   logic       doe_r;
   logic       hdr_rd;
   logic       hdr_wr;
   logic [3:0] bit_n;
   logic [1:0] byte_n;
   logic [7:0] shreg;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       bit_end;
   logic       ack_end;
   logic       data_end;
   logic       addr_hit;
   logic       rd_phase;

   assign scl_rise   = scl & ~scl_q;
   assign scl_fall   = ~scl & scl_q;
   assign start_seen = scl & scl_q & sda_q & ~sda;
   // A bit counts only when its clock falls again; stop and Sr rises never do
   assign bit_end    = scl_fall & bit_open;
   assign ack_end    = bit_end & (bit_n == ACK_BIT);
   assign data_end   = bit_end & (bit_n != ACK_BIT);
   assign addr_hit   = shreg[7:1] == TARGET_ADDR;
   assign rd_phase   = (byte_n != 2'h0) & hdr_rd;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || start_seen) begin
         bit_open <= 1'b0;
      end else if (scl_rise) begin
         bit_open <= 1'b1;
      end else if (scl_fall) begin
         bit_open <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sda_r <= 1'b1;
         hoe_r <= 1'b1;
         doe_r <= 1'b1;
      end else if (scl_rise) begin
         sda_r <= sda;
         hoe_r <= host_sda_oe_n;
         doe_r <= dev_sda_oe_n;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || start_seen) begin
         bit_n  <= 4'h0;
         byte_n <= 2'h0;
      end else if (ack_end) begin
         bit_n <= 4'h0;
         if (byte_n != 2'h3) begin
            byte_n <= byte_n + 2'h1;
         end
      end else if (data_end) begin
         bit_n <= bit_n + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         shreg <= 8'h00;
      end else if (data_end) begin
         shreg <= {shreg[6:0], sda_r};
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hdr_rd <= 1'b0;
         hdr_wr <= 1'b0;
      end else if (ack_end && byte_n == 2'h0) begin
         hdr_rd <= addr_hit & shreg[0];
         hdr_wr <= addr_hit & ~shreg[0];
      end
   end

   sequence s_addr_ack_rise;
      scl_rise && bit_n == ACK_BIT && byte_n == 2'h0 && addr_hit;
   endsequence
   sequence s_scl_held;
      scl [*8];
   endsequence

   property p_addr_ack;
      ack_end && byte_n == 2'h0 && addr_hit |-> !sda_r;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("matching address byte not acknowledged");

   property p_addr_nack;
      ack_end && byte_n == 2'h0 && !addr_hit |-> sda_r && doe_r;
   endproperty
   a_addr_nack: assert property (p_addr_nack)
      else $error("foreign address byte acknowledged");

   property p_wr_ack;
      ack_end && byte_n != 2'h0 && hdr_wr |-> !doe_r;
   endproperty
   a_wr_ack: assert property (p_wr_ack)
      else $error("write byte not acknowledged by target");

   property p_rd_release_ack;
      ack_end && rd_phase |-> doe_r;
   endproperty
   a_rd_release_ack: assert property (p_rd_release_ack)
      else $error("target held data during master acknowledge");

   property p_rd_host_quiet;
      data_end && rd_phase |-> hoe_r;
   endproperty
   a_rd_host_quiet: assert property (p_rd_host_quiet)
      else $error("host drove data during a read byte");

   property p_dev_quiet;
      data_end && !rd_phase |-> doe_r;
   endproperty
   a_dev_quiet: assert property (p_dev_quiet)
      else $error("target drove data outside its turn");

   property p_dev_on_fall;
      $changed(dev_sda_oe_n) |-> !scl && $past(scl);
   endproperty
   a_dev_on_fall: assert property (p_dev_on_fall)
      else $error("target data changed away from a clock fall");

   property p_ack_steady;
      s_addr_ack_rise |-> (!sda) throughout s_scl_held;
   endproperty
   a_ack_steady: assert property (p_ack_steady)
      else $error("acknowledge not held while clock high");
endmodule

// File: led_driver_i2c_regs_test.sv
// Self-checking bench: host end drives the target end over the shared link.
// Assumes a 20 MHz clk for both ends; host makes the serial clock.
`timescale 1ns/1ns
module led_driver_i2c_regs_test;
   import ldi_pkg::*;
   typedef struct {logic [7:0] ptr; logic [7:0] wr; logic [7:0] exp;} ldi_row_t;
   localparam logic [7:0] AW    = {TARGET_ADDR, 1'b0};
   localparam logic [7:0] AR    = {TARGET_ADDR, 1'b1};
   localparam int         LIMIT = 90000;
   logic       clk;
   logic       rst;
   logic       linear_mode;
   logic       cmd_valid;
   logic       cmd_nack;
   logic       cmd_ready;
   logic       done;
   logic       ack_ok;
   logic [1:0] cmd_op;
   logic [7:0] cmd_byte;
   logic [7:0] rd_byte;
   logic [7:0] cur_a;
   logic [7:0] cur_b;
   logic [7:0] cur_c;
   logic [5:0] leds;
   logic [7:0] none[$];
   int         bad_count = 0;
   int         num_checks = 0;
   int         cycles = 0;
   ldi_row_t   rows[8] = '{'{8'h00, 8'hc8, 8'hc8}, '{8'h01, 8'ha0, 8'ha0}, '{8'h02, 8'h19, 8'h19},
                           '{8'h03, 8'hff, 8'h3f}, '{8'h04, 8'h23, 8'h23}, '{8'h05, 8'hdc, 8'hdc},
                           '{8'h06, 8'h7f, 8'h7f}, '{8'h07, 8'h01, 8'h01}};

   ldi_link_if link ();
   ldi_device u_ldi_device (.clk(clk), .rst(rst), .link(link), .linear_mode(linear_mode),
      .first_bank_led_one(leds[0]), .first_bank_led_two(leds[1]), .second_bank_led_one(leds[2]),
      .second_bank_led_two(leds[3]), .third_bank_led_one(leds[4]), .third_bank_led_two(leds[5]),
      .bank_a_current(cur_a), .bank_b_current(cur_b), .bank_c_current(cur_c));
   ldi_host u_ldi_host (.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_byte(cmd_byte), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready), .done(done),
      .rd_byte(rd_byte), .ack_ok(ack_ok));
   ldi_link_monitor u_ldi_link_monitor (.clk(clk), .rst(rst), .scl(link.scl),
      .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n), .sda(link.sda));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic results();
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // A hung handshake would otherwise stall the run forever
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         results();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Entered 2 ns after a clock edge; request held until the accepting edge
   task automatic op(input logic [1:0] o, input logic [7:0] b, input logic nk);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1) begin
         @(posedge clk);
         #2;
      end
      cmd_op = o;
      cmd_byte = b;
      cmd_nack = nk;
      cmd_valid = 1'b1;
      @(posedge clk);
      #2;
      cmd_valid = 1'b0;
      while (done !== 1'b1 && n < 600) begin
         @(posedge clk);
         #2;
         n++;
      end
      chk({7'h00, done}, 8'h01);
   endtask

   task automatic wbyte(input logic [7:0] b);
      op(OP_WRITE, b, 1'b0);
      chk({7'h00, ack_ok}, 8'h01);
   endtask

   task automatic rbyte(input logic nk, input logic [7:0] e);
      op(OP_READ, 8'h00, nk);
      chk(rd_byte, e);
   endtask

   task automatic wseq(input logic [7:0] p, input logic [7:0] d[$]);
      op(OP_START, 8'h00, 1'b0);
      wbyte(AW);
      wbyte(p);
      foreach (d[i]) begin
         wbyte(d[i]);
      end
      op(OP_STOP, 8'h00, 1'b0);
   endtask

   task automatic rseq(input logic [7:0] e[$]);
      op(OP_START, 8'h00, 1'b0);
      wbyte(AR);
      foreach (e[i]) begin
         rbyte(i == e.size() - 1, e[i]);
      end
      op(OP_STOP, 8'h00, 1'b0);
   endtask

   task automatic rreg(input logic [7:0] p, input logic [7:0] e);
      op(OP_START, 8'h00, 1'b0);
      wbyte(AW);
      wbyte(p);
      op(OP_START, 8'h00, 1'b0);
      wbyte(AR);
      rbyte(1'b1, e);
      op(OP_STOP, 8'h00, 1'b0);
   endtask

   task automatic led_chk(input logic [5:0] e);
      repeat (8) @(posedge clk);
      #2;
      chk({2'h0, leds}, {2'h0, e});
   endtask

   initial begin
      rst = 1'b1;
      linear_mode = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = OP_START;
      cmd_byte = 8'h00;
      cmd_nack = 1'b0;
      repeat (5) @(posedge clk);
      #2;
      rst = 1'b0;
      chk(cur_a, RESET_VALUE);
      wseq(REG_A_CURRENT, none);
      rseq('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      foreach (rows[i]) begin
         wseq(rows[i].ptr, '{rows[i].wr});
         rreg(rows[i].ptr, rows[i].exp);
      end
      chk(cur_a, 8'hc8);
      chk(cur_b, 8'ha0);
      chk(cur_c, 8'h19);
      wseq(REG_A_CURRENT, '{8'h11, 8'h22, 8'h33, 8'h3c, 8'h44});
      rseq('{8'h44, 8'h22, 8'h33, 8'h3c});
      chk(cur_a, 8'h44);
      op(OP_START, 8'h00, 1'b0);
      wbyte(AW);
      wbyte(REG_B_DUTY);
      op(OP_START, 8'h00, 1'b0);
      wbyte(AW);
      wbyte(8'h5a);
      op(OP_STOP, 8'h00, 1'b0);
      rseq('{8'h5a});
      op(OP_START, 8'h00, 1'b0);
      op(OP_WRITE, {TARGET_ADDR ^ 7'h01, 1'b0}, 1'b0);
      chk({7'h00, ack_ok}, 8'h00);
      op(OP_STOP, 8'h00, 1'b0);
      wseq(REG_CHAN_EN, '{8'h33, 8'h00, 8'hff, 8'hff});
      wseq(REG_C_DUTY, '{8'hff});
      led_chk(6'h33);
      wseq(REG_GLOBAL, '{8'hff});
      led_chk(6'h00);
      linear_mode = 1'b1;
      led_chk(6'h00);
      wseq(REG_GLOBAL, '{8'h00});
      led_chk(6'h33);
      wseq(REG_A_DUTY, '{8'h00});
      led_chk(6'h30);
      rst = 1'b1;
      repeat (3) @(posedge clk);
      #2;
      rst = 1'b0;
      chk(cur_a, RESET_VALUE);
      results();
   end
endmodule
